/* File: verilog/xpsc_ctrl.sv */
// Top of the crosspoint switch control: command decode, enables and slaves.
// Assumes all pins are synchronous to CLK_SYS_I and strobes last over a cycle.
// Output enables drive the analog buffers; low means high impedance.
`timescale 1ns/1ps

// Operation
// RULE1: Reset disables outputs, all select first input.
// RULE2: Disabled output goes high impedance.
// RULE3: Serial enable always connects output to ground.
// RULE4: Write strobe acts on its rising edge.
// RULE5: Edge mode latches on rise; level transparent low.
// RULE6: Write needs high select and low select.
// RULE7: Parallel mode uses output select and code.
// RULE8: Each output has master and slave nibble.
// RULE9: Parallel write loads addressed master nibble.
// RULE10: Codes 1011 to 1111 act at once.
// RULE11: Input or ground code never enables output.
// RULE12: Codes 1011/1100 disable/enable addressed output.
// RULE13: Codes 1101/1110 disable/enable all outputs.
// RULE14: Code 1111 copies masters only when latch high.
// RULE15: Host avoids 1001 and 1010 in parallel.
// RULE16: Serial shift loads all masters, no address.
// RULE17: Serial order output zero first, MSB first.
// RULE18: Serial masters move to slaves on latch.
// RULE19: Serial input or ground nibble never enables.
// RULE20: Serial 1001 enables output onto ground.
// RULE21: Serial 1010 disables and forgets selection.
// RULE22: Host avoids nibbles 1011 to 1111 serially.
// RULE23: Top code bit marks command versus channel.
// RULE24: Serial bits in per strobe, displaced bits out.
module xpsc_ctrl
   import xpsc_pkg::*;
(
   // Clock and reset.
   input wire logic CLK_SYS_I,
   input wire logic NRST_I,
   // Write strobe and chip selects.
   input wire logic WR_I,
   input wire logic CE_I,
   input wire logic CE_N_I,
   // Mode, address and command pins.
   input wire logic INTF_SEL_I,
   input wire logic [XPSC_SEL_W-1:0] OUTPUT_SEL_I,
   input wire logic [XPSC_NIB_W-1:0] CMD_CODE_I,
   // Serial output half of the shared data pin.
   output logic SER_DATA_O,
   output logic SER_DATA_OE_O,
   // Transfer strobe and trigger select.
   input wire logic LATCH_I,
   input wire logic TRIG_SEL_I,
   // Applied switch state.
   output logic [XPSC_NUM_OUT-1:0] OUT_EN_O,
   output logic [XPSC_WORD_W-1:0] OUT_SEL_O
);

   // Nibble of output i inside the master word, output zero on top.
   function automatic xpsc_nib_t nib_of(input logic [XPSC_WORD_W-1:0] w,
                                        input int unsigned i);
      nib_of = w[XPSC_WORD_W-1-i*XPSC_NIB_W -: XPSC_NIB_W];
   endfunction

   logic wr_lvl;
   logic wr_rise;
   logic latch_rise;
   logic par_mode;
   logic par_wr;
   logic ser_wr;
   logic is_cmd;
   logic sel_load;
   logic cmd_dis_one;
   logic cmd_en_one;
   logic cmd_dis_all;
   logic cmd_en_all;
   logic sw_latch;
   logic hw_latch;
   logic xfer;
   logic [XPSC_WORD_W-1:0] word;
   logic [XPSC_NUM_OUT-1:0] en_q;
   logic [XPSC_NUM_OUT-1:0] en_d;
   logic [XPSC_NUM_OUT-1:0][XPSC_NIB_W-1:0] slave_q;
   logic [XPSC_NUM_OUT-1:0][XPSC_NIB_W-1:0] slave_d;

   // Master store requests travel together in one interface.
   xpsc_master_if mst ();

   // The strobe only counts while both chip selects agree.
   // Gating comes before edge detection, so a select that opens while the
   // strobe is already high is seen as a rise. Hosts keep the selects steady
   // around each strobe pulse, which costs nothing and avoids a stray write.
   assign wr_lvl = WR_I & CE_I & ~CE_N_I; // [RULE6]

   xpsc_edge u_wr_edge (
      .clk_i (CLK_SYS_I),
      .nrst_i (NRST_I),
      .lvl_i (wr_lvl),
      .rise_o (wr_rise) // [RULE4]
   );

   // The transfer strobe has its own detector and is not gated by the selects,
   // so one latch line can update every part that shares it.
   xpsc_edge u_latch_edge (
      .clk_i (CLK_SYS_I),
      .nrst_i (NRST_I),
      .lvl_i (LATCH_I),
      .rise_o (latch_rise)
   );

   // Mode split and command decode; every write request is qualified by the write edge.
   assign par_mode = (INTF_SEL_I == XPSC_MODE_PAR); // [RULE7]
   assign par_wr = wr_rise & par_mode;
   assign ser_wr = wr_rise & ~par_mode;
   assign is_cmd = CMD_CODE_I[XPSC_CMD_BIT]; // [RULE23]
   assign sel_load = par_wr & (~is_cmd | (CMD_CODE_I == XPSC_CODE_GND)); // [RULE11]
   // Codes 1001 and 1010 fall through every decode here and do nothing.
   assign cmd_dis_one = par_wr & (CMD_CODE_I == XPSC_CODE_DIS_ONE); // [RULE10] [RULE15]
   assign cmd_en_one = par_wr & (CMD_CODE_I == XPSC_CODE_EN_ONE);
   assign cmd_dis_all = par_wr & (CMD_CODE_I == XPSC_CODE_DIS_ALL);
   assign cmd_en_all = par_wr & (CMD_CODE_I == XPSC_CODE_EN_ALL);
   assign sw_latch = par_wr & (CMD_CODE_I == XPSC_CODE_SW_LATCH) & LATCH_I; // [RULE14]

   // Level mode keeps the slaves transparent; edge mode waits for the rise.
   // In level mode a slave copies its master every cycle the strobe is low, so
   // a switch follows a write two edges later. Edge mode trades that latency
   // for all eight outputs changing together on one rise.
   assign hw_latch = (TRIG_SEL_I == XPSC_TRIG_EDGE) ? latch_rise : ~LATCH_I; // [RULE5] [RULE18]
   assign xfer = hw_latch | sw_latch;

   // Requests to the master store.
   assign mst.shift_en = ser_wr; // [RULE16] [RULE24]
   assign mst.ser_bit = CMD_CODE_I[XPSC_SER_IN_BIT];
   assign mst.load_en = sel_load; // [RULE9]
   assign mst.load_idx = OUTPUT_SEL_I;
   assign mst.load_nib = CMD_CODE_I;
   assign word = mst.word;

   xpsc_master_reg u_master (
      .clk_i (CLK_SYS_I),
      .nrst_i (NRST_I),
      .bus (mst.store)
   );

   // Next enables and slaves. Enable commands only occur in parallel mode,
   // and a parallel transfer never touches enables, so nothing collides.
   always_comb begin
      en_d = en_q;
      slave_d = slave_q;
      if (cmd_dis_all) begin
         en_d = '0; // [RULE13]
      end
      if (cmd_en_all) begin
         en_d = '1; // [RULE13]
      end
      if (cmd_dis_one) begin
         en_d[OUTPUT_SEL_I] = 1'b0; // [RULE12]
      end
      if (cmd_en_one) begin
         en_d[OUTPUT_SEL_I] = 1'b1; // [RULE12]
      end
      if (xfer) begin
         for (int i = 0; i < XPSC_NUM_OUT; i++) begin
            if (par_mode) begin
               slave_d[i] = nib_of(word, i); // [RULE8]
            end else begin
               unique case (nib_of(word, i))
                  XPSC_CODE_SER_EN: begin
                     en_d[i] = 1'b1; // [RULE20] [RULE3]
                     slave_d[i] = XPSC_CODE_GND;
                  end
                  XPSC_CODE_SER_DIS: begin
                     en_d[i] = 1'b0; // [RULE21]
                     slave_d[i] = XPSC_CODE_GND;
                  end
                  4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, XPSC_CODE_GND: begin
                     slave_d[i] = nib_of(word, i); // [RULE19] [RULE18]
                  end
                  // Illegal nibbles leave the output alone rather than guess.
                  default: begin
                     slave_d[i] = slave_q[i]; // [RULE22]
                  end
               endcase
            end
         end
      end
   end

   // Applied state; reset leaves every output off on the first input.
   always_ff @(posedge CLK_SYS_I) begin
      if (!NRST_I) begin
         en_q <= XPSC_EN_RST; // [RULE1]
         slave_q <= {XPSC_NUM_OUT{XPSC_SEL_RST}}; // [RULE1]
      end else begin
         en_q <= en_d;
         slave_q <= slave_d;
      end
   end

   // Outputs. The serial pin is only driven while the part is in serial mode.
   // The pin direction follows the mode pin with no delay, so the host must
   // release its half of the shared pin before it selects serial mode.
   assign OUT_EN_O = en_q; // [RULE2]
   assign OUT_SEL_O = slave_q;
   assign SER_DATA_O = word[XPSC_WORD_W-1]; // [RULE24]
   assign SER_DATA_OE_O = ~par_mode;

   // Every effect of a decode lands on the next edge, so the checks below, bar the reset
   // check, look one cycle after their trigger and are muted while reset is held.
   default clocking xpsc_cb @(posedge CLK_SYS_I);
   endclocking
   default disable iff (!NRST_I);

   // Reset leaves every output off and on the first input.
   reset_state_a: assert property ( // [RULE1]
      $rose(NRST_I) |-> OUT_EN_O == 8'h00 && OUT_SEL_O == 32'h0000_0000)
      else $error("state after reset is not all off on first input");

   // A write with either select closed is lost.
   gate_blocks_a: assert property ( // [RULE6]
      (!CE_I || CE_N_I) |=> $stable(word))
      else $error("master changed without both chip selects");

   // Single and global enable commands act on the next edge.
   disable_one_a: assert property ( // [RULE12]
      cmd_dis_one |=> !OUT_EN_O[$past(OUTPUT_SEL_I)] && $stable(word))
      else $error("single disable failed or touched master");

   enable_one_a: assert property ( // [RULE12]
      cmd_en_one |=> OUT_EN_O[$past(OUTPUT_SEL_I)] && $stable(word))
      else $error("single enable failed or touched master");

   all_enable_a: assert property ( // [RULE13]
      cmd_en_all |=> OUT_EN_O == 8'hff && $stable(word))
      else $error("enable all failed");

   all_disable_a: assert property ( // [RULE13]
      cmd_dis_all |=> OUT_EN_O == 8'h00 && $stable(word))
      else $error("disable all failed");

   sel_no_enable_a: assert property ( // [RULE11]
      sel_load |=> $stable(OUT_EN_O)
         && nib_of(word, 32'($past(OUTPUT_SEL_I))) == $past(CMD_CODE_I))
      else $error("selection write changed enables or missed master");

   // Transfer paths: the software latch and the hardware strobe.
   sw_latch_nop_a: assert property ( // [RULE14]
      (par_wr && CMD_CODE_I == XPSC_CODE_SW_LATCH && !LATCH_I && TRIG_SEL_I)
         |=> $stable(OUT_SEL_O))
      else $error("software latch acted with transfer strobe low");

   edge_hold_a: assert property ( // [RULE5]
      (TRIG_SEL_I && !latch_rise && !sw_latch) |=> $stable(OUT_SEL_O))
      else $error("slaves moved in edge mode without a latch");

   level_follow_a: assert property ( // [RULE5]
      (!TRIG_SEL_I && !LATCH_I && par_mode) |=> OUT_SEL_O[3:0] == nib_of($past(word), 0))
      else $error("slave not transparent in level mode");

   // Serial decode of the enable and disable nibbles.
   ser_enable_gnd_a: assert property ( // [RULE20]
      (xfer && !par_mode && nib_of(word, 0) == XPSC_CODE_SER_EN)
         |=> OUT_EN_O[0] && OUT_SEL_O[3:0] == XPSC_CODE_GND)
      else $error("serial enable did not ground the output");

   ser_disable_a: assert property ( // [RULE21]
      (xfer && !par_mode && nib_of(word, 1) == XPSC_CODE_SER_DIS)
         |=> !OUT_EN_O[1] && OUT_SEL_O[7:4] == XPSC_CODE_GND)
      else $error("serial disable did not drop the output");

   ser_out_a: assert property ( // [RULE24]
      ser_wr |=> SER_DATA_O == $past(word[30]) && SER_DATA_OE_O)
      else $error("serial output did not follow the chain");

   // A parallel transfer moves selections only; enables stay as they were.
   par_xfer_en_a: assert property ( // [RULE11]
      (xfer && par_mode && !cmd_dis_one && !cmd_en_one && !cmd_dis_all && !cmd_en_all)
         |=> $stable(OUT_EN_O))
      else $error("parallel transfer changed an enable");

   // Whole-word transfer: the last output moves together with the first.
   par_xfer_all_a: assert property ( // [RULE5]
      (xfer && par_mode) |=> OUT_SEL_O[31:28] == nib_of($past(word), 7))
      else $error("last output missed the parallel transfer");

   // Command codes other than the ground code never touch the master store.
   cmd_master_keep_a: assert property ( // [RULE12] [RULE13] [RULE14]
      (par_wr && is_cmd && !sel_load) |=> $stable(word))
      else $error("command code changed a master nibble");

   // A serial bit alone moves the chain, not the applied state.
   ser_shift_only_a: assert property ( // [RULE16]
      (ser_wr && !xfer) |=> $stable(OUT_SEL_O) && $stable(OUT_EN_O))
      else $error("serial shift changed the applied state");

   // The new bit enters at the bottom of the chain.
   ser_in_bit_a: assert property ( // [RULE24]
      ser_wr |=> word[0] == $past(CMD_CODE_I[XPSC_SER_IN_BIT]))
      else $error("serial input bit not taken");

   // A serial channel or ground nibble applies as is and keeps the enable.
   ser_sel_keep_a: assert property ( // [RULE19]
      (xfer && !par_mode && nib_of(word, 2) <= XPSC_CODE_GND)
         |=> $stable(OUT_EN_O[2]) && OUT_SEL_O[11:8] == nib_of($past(word), 2))
      else $error("serial selection enabled an output or was lost");

endmodule // xpsc_ctrl

/* File: verilog/xpsc_pkg.sv */
// Constants and types shared by the crosspoint switch control block.
// Assumes every file that uses it imports the whole package.
package xpsc_pkg;

   // Geometry of the switch and of the serial word.
   localparam int unsigned XPSC_NUM_OUT = 8;
   localparam int unsigned XPSC_NIB_W = 4;
   localparam int unsigned XPSC_SEL_W = 3;
   localparam int unsigned XPSC_WORD_W = 32;

   // Bit positions inside the command code pins.
   localparam int unsigned XPSC_CMD_BIT = 3;
   localparam int unsigned XPSC_SER_IN_BIT = 0;

   // Pin levels that select modes.
   localparam logic XPSC_MODE_PAR = 1'b0;
   localparam logic XPSC_TRIG_EDGE = 1'b1;

   // Command and nibble codes.
   localparam logic [3:0] XPSC_CODE_GND = 4'h8;
   localparam logic [3:0] XPSC_CODE_SER_EN = 4'h9;
   localparam logic [3:0] XPSC_CODE_SER_DIS = 4'ha;
   localparam logic [3:0] XPSC_CODE_DIS_ONE = 4'hb;
   localparam logic [3:0] XPSC_CODE_EN_ONE = 4'hc;
   localparam logic [3:0] XPSC_CODE_DIS_ALL = 4'hd;
   localparam logic [3:0] XPSC_CODE_EN_ALL = 4'he;
   localparam logic [3:0] XPSC_CODE_SW_LATCH = 4'hf;

   // Reset values: all outputs off and following the first input.
   localparam logic [3:0] XPSC_SEL_RST = 4'h0;
   localparam logic [7:0] XPSC_EN_RST = 8'h00;
   localparam logic [31:0] XPSC_WORD_RST = 32'h0000_0000;
   localparam logic XPSC_LVL_RST = 1'b1;

   typedef logic [3:0] xpsc_nib_t;

endpackage

/* File: verilog/xpsc_master_if.sv */
// Interface between the command decoder and the master register store.
// Assumes both ends run on the same system clock.
`timescale 1ns/1ps
interface xpsc_master_if;
   import xpsc_pkg::*;

   logic shift_en;
   logic ser_bit;
   logic load_en;
   logic [XPSC_SEL_W-1:0] load_idx;
   xpsc_nib_t load_nib;
   logic [XPSC_WORD_W-1:0] word;

   // The store owns the word; the decoder drives the requests.
   modport store (
      input shift_en, ser_bit, load_en, load_idx, load_nib,
      output word
   );
   modport ctrl (
      output shift_en, ser_bit, load_en, load_idx, load_nib,
      input word
   );
endinterface // xpsc_master_if

/* File: verilog/xpsc_edge.sv */
// Rising edge detector for a synchronous level.
// Assumes the level is already synchronous to the clock.
`timescale 1ns/1ps
module xpsc_edge
   import xpsc_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic nrst_i,
   // Level in, edge out.
   input wire logic lvl_i,
   output logic rise_o
);

   logic lvl_q;

   // Reset to high so a level already high at release is no edge.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         lvl_q <= XPSC_LVL_RST;
      end else begin
         lvl_q <= lvl_i;
      end
   end

   assign rise_o = lvl_i & ~lvl_q;

   // An edge lasts one cycle and cannot repeat at once.
   rise_single_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE4]
      rise_o |=> !rise_o)
      else $error("edge pulse longer than one cycle");

endmodule // xpsc_edge

/* File: verilog/xpsc_master_reg.sv */
// Master register store: one nibble per output, also the serial chain.
// Assumes shift and load requests never arrive in the same cycle.
`timescale 1ns/1ps
module xpsc_master_reg
   import xpsc_pkg::*;
(
   // Clock and reset.
   input wire logic clk_i,
   input wire logic nrst_i,
   // Request side.
   xpsc_master_if.store bus
);

   logic [XPSC_WORD_W-1:0] word_q;
   logic [4:0] nib_lo;

   // Output zero sits in the top nibble, so a left shift fills in order.
   assign nib_lo = 5'(XPSC_WORD_W - XPSC_NIB_W) - 5'({bus.load_idx, 2'b00});
   assign bus.word = word_q;

   // The whole chain is the master store; a shift moves all outputs at once.
   always_ff @(posedge clk_i) begin
      if (!nrst_i) begin
         word_q <= XPSC_WORD_RST;
      end else if (bus.shift_en) begin
         word_q <= {word_q[XPSC_WORD_W-2:0], bus.ser_bit}; // [RULE16] [RULE17] [RULE24]
      end else if (bus.load_en) begin
         word_q[nib_lo +: XPSC_NIB_W] <= bus.load_nib; // [RULE9]
      end
   end

   shift_order_a: assert property (@(posedge clk_i) disable iff (!nrst_i) // [RULE17]
      bus.shift_en |=> word_q[0] == $past(bus.ser_bit) && word_q[31:1] == $past(word_q[30:0]))
      else $error("serial chain shifted in the wrong order");

endmodule // xpsc_master_reg

/* File: test/xpsc_host.sv */
// Behavioural host that drives the command pins of the switch control.
// Assumes a free-running system clock; pins change just after its rising edge.
`timescale 1ns/1ps
module xpsc_host
   import xpsc_pkg::*;
(
   // Clock.
   input wire logic clk_i,
   // Strobe and chip selects.
   output logic wr_o,
   output logic ce_o,
   output logic ce_n_o,
   // Mode, address and code.
   output logic intf_sel_o,
   output logic [2:0] out_sel_o,
   output logic [3:0] cmd_o,
   // Transfer strobe and trigger select.
   output logic latch_o,
   output logic trig_o
);
   // Idle levels: strobe low, chip selected, parallel edge mode.
   initial begin
      wr_o = 1'b0;
      ce_o = 1'b1;
      ce_n_o = 1'b0;
      intf_sel_o = 1'b0;
      out_sel_o = 3'h0;
      cmd_o = 4'h0;
      latch_o = 1'b0;
      trig_o = 1'b1;
   end

   // One strobe pulse; the two low cycles after it keep writes three cycles apart.
   task automatic wr_cycle(input logic [2:0] a, input logic [3:0] c, input logic ce,
                           input logic ce_n);
      @(posedge clk_i);
      out_sel_o <= a;
      cmd_o <= c; // Codes 1001 and 1010 are never sent in parallel mode.
      ce_o <= ce;
      ce_n_o <= ce_n;
      wr_o <= 1'b1;
      @(posedge clk_i);
      wr_o <= 1'b0;
      @(posedge clk_i);
      #1;
   endtask

   // One serial bit per strobe; only nibbles up to 1010 are ever shifted.
   task automatic ser_bit(input logic b);
      wr_cycle(3'h0, {3'h0, b}, 1'b1, 1'b0);
   endtask

   // Transfer strobe level; the effect shows on the next edge.
   task automatic set_latch(input logic v);
      @(posedge clk_i);
      latch_o <= v;
      @(posedge clk_i);
      @(posedge clk_i);
      #1;
   endtask

   // Interface and trigger mode change.
   task automatic set_mode(input logic intf, input logic trig);
      @(posedge clk_i);
      intf_sel_o <= intf;
      trig_o <= trig;
      @(posedge clk_i);
      @(posedge clk_i);
      #1;
   endtask
endmodule // xpsc_host

/* File: test/xpsc_ctrl_tb.sv */
// Self-checking bench for the crosspoint switch control top.
// Assumes the host model drives every command pin.
`timescale 1ns/1ps
module xpsc_ctrl_tb;
   import xpsc_pkg::*;

   logic clk = 1'b0;
   logic nrst = 1'b0;
   logic wr, ce, ce_n, intf, latch, trig, ser, ser_oe;
   logic [2:0] osel;
   logic [3:0] cmd, cmd_pin;
   logic [7:0] en;
   logic [31:0] sel;
   logic [3:0] m [8];
   int n_mismatch = 0;
   int checked = 0;

   // Clock at 40 MHz.
   always #12.5 clk = ~clk;

   // The shared data pin carries the device's serial output while it drives it.
   assign cmd_pin = {cmd[3:2], ser_oe ? ser : cmd[1], cmd[0]};

   xpsc_host host (.clk_i(clk), .wr_o(wr), .ce_o(ce), .ce_n_o(ce_n), .intf_sel_o(intf),
      .out_sel_o(osel), .cmd_o(cmd), .latch_o(latch), .trig_o(trig));

   xpsc_ctrl DUT (.CLK_SYS_I(clk), .NRST_I(nrst), .WR_I(wr), .CE_I(ce), .CE_N_I(ce_n),
      .INTF_SEL_I(intf), .OUTPUT_SEL_I(osel), .CMD_CODE_I(cmd_pin), .SER_DATA_O(ser),
      .SER_DATA_OE_O(ser_oe), .LATCH_I(latch), .TRIG_SEL_I(trig), .OUT_EN_O(en),
      .OUT_SEL_O(sel));

   // Comparison with case equality so an unknown never matches.
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
      checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t %s: seen %h expected %h", $time, what, seen, exp);
      end
   endtask

   // Expected slave word from the master model, output i at nibble i.
   function automatic logic [31:0] sel_word();
      logic [31:0] w;
      for (int i = 0; i < 8; i++) w[4*i +: 4] = m[i];
      return w;
   endfunction

   task automatic final_report();
      $display("Comparisons %0d, mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // Parallel writes in edge mode wait for the transfer strobe rise.
   task automatic t_par_edge();
      host.set_mode(1'b0, 1'b1);
      for (int i = 0; i < 8; i++) begin
         m[i] = (i == 6) ? 4'h8 : 4'(7 - i);
         host.wr_cycle(3'(i), m[i], 1'b1, 1'b0);
      end
      chk(sel, 32'h0000_0000, "slaves before latch");
      chk(en, 8'h00, "enables after selects");
      host.set_latch(1'b1);
      chk(sel, sel_word(), "slaves after latch rise");
      chk(en, 8'h00, "enables after transfer");
      $display("t_par_edge done");
   endtask

   // Enable commands act at once, gated by both chip selects.
   task automatic t_enables();
      host.wr_cycle(3'h0, 4'he, 1'b0, 1'b0);
      host.wr_cycle(3'h0, 4'he, 1'b1, 1'b1);
      chk(en, 8'h00, "write without chip select");
      host.wr_cycle(3'h3, 4'hc, 1'b1, 1'b0);
      chk(en, 8'h08, "enable one");
      host.wr_cycle(3'h1, 4'he, 1'b1, 1'b0);
      chk(en, 8'hff, "enable all");
      host.wr_cycle(3'h5, 4'hb, 1'b1, 1'b0);
      chk(en, 8'hdf, "disable one");
      host.wr_cycle(3'h2, 4'hd, 1'b1, 1'b0);
      chk(en, 8'h00, "disable all, outputs float");
      $display("t_enables done");
   endtask

   // Software latch copies only while the transfer strobe is high.
   task automatic t_soft_latch();
      logic [31:0] s;
      s = sel_word();
      m[0] = 4'h7;
      host.wr_cycle(3'h0, 4'h7, 1'b1, 1'b0);
      chk(sel, s, "held high strobe, no transfer");
      host.wr_cycle(3'h4, 4'hf, 1'b1, 1'b0);
      chk(sel, sel_word(), "software latch, masters kept");
      s = sel_word();
      host.set_latch(1'b0);
      m[1] = 4'h6;
      host.wr_cycle(3'h1, 4'h6, 1'b1, 1'b0);
      host.wr_cycle(3'h0, 4'hf, 1'b1, 1'b0);
      chk(sel, s, "software latch ignored");
      $display("t_soft_latch done");
   endtask

   // Level mode with the strobe low passes masters through.
   task automatic t_level();
      host.set_mode(1'b0, 1'b0);
      m[2] = 4'h3;
      host.wr_cycle(3'h2, 4'h3, 1'b1, 1'b0);
      @(posedge clk);
      #1;
      chk(sel, sel_word(), "transparent slaves");
      $display("t_level done");
   endtask

   // Serial word through the chain, then one transfer decodes every nibble.
   task automatic t_serial();
      logic [63:0] cat;
      logic [31:0] w;
      w = 32'h9a58_1234;
      host.wr_cycle(3'h1, 4'hc, 1'b1, 1'b0);
      host.set_mode(1'b1, 1'b1);
      chk(ser_oe, 1'b1, "data pin driven in serial mode");
      cat = {m[0], m[1], m[2], m[3], m[4], m[5], m[6], m[7], w};
      for (int j = 1; j <= 32; j++) begin
         host.ser_bit(w[32-j]);
         chk(ser, cat[63-j], "displaced bit");
      end
      chk(sel, sel_word(), "no transfer before latch");
      host.set_latch(1'b1);
      chk(sel, 32'h4321_8588, "serial transfer");
      chk(en, 8'h01, "serial enables");
      $display("t_serial done");
   endtask

   // Main sequence.
   initial begin
      repeat (20) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      #1;
      chk(en, 8'h00, "reset enables");
      chk(sel, 32'h0000_0000, "reset selects");
      chk(ser, 1'b0, "reset chain");
      chk(ser_oe, 1'b0, "data pin released in parallel mode");
      t_par_edge();
      t_enables();
      t_soft_latch();
      t_level();
      t_serial();
      final_report();
   end

   // Watchdog cuts a hang short.
   initial begin
      #1ms;
      n_mismatch++;
      final_report();
   end
endmodule // xpsc_ctrl_tb
